// ---- rtl/i2css_top.sv ----
// Serial slave status, control and data register block with an APB slave port.
//
// Summary of operation
// (R1) Each completed 8-bit data byte sets the byte-done flag and raises an interrupt.
// (R2) A received address equal to own address sets address-match and interrupts.
// (R3) A START condition on the bus sets the bus-busy flag.
// (R4) The eighth bit after START is stored as the master read request.
// (R5) Transmit-select one makes the block transmit, zero makes it receive.
// (R6) After eight received bits the ack-to-send value drives SDA on clock nine.
// (R7) Software clears ack-to-send before each further byte it wants acknowledged.
// (R8) With match-wake enabled, an address match raises the wake output.
// (R9) After eight sent bits SDA on clock nine is stored as ack-received-n.
// (R10) Transmission continues while ack-received-n is zero and stops when one.
// (R11) When the master withholds acknowledge the transmitter releases SDA.
// (R12) One data register holds the byte sent or received, shared by both modes.
// (R13) Software loads the byte to send into the data register beforehand.
// (R14) Each received byte becomes readable in the data register on completion.
// (R15) The data register is eight bits, read and write, undefined after reset.
// (R16) A STOP condition on the bus clears the bus-busy flag.
// (R17) Byte-done clears while a byte shifts and sets after its eighth bit.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "i2css_consts.svh"

module i2css_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic irq,
    output logic wake
);

    i2css_pkg::i2css_pins_t pin_s1_reg;
    i2css_pkg::i2css_pins_t pin_s2_reg;
    i2css_pkg::i2css_pins_t pin_s3_reg;
    i2css_pkg::i2css_state_t st_reg;
    i2css_pkg::i2css_state_t st_next;
    i2css_pkg::i2css_ctrl_t ctl_reg;
    i2css_pkg::i2css_ctrl_t ctl_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic [7:0] dat_reg;
    logic [7:0] dat_next;
    logic [6:0] own_reg;
    logic [6:0] own_next;
    logic [1:0] int_reg;
    logic [1:0] int_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic oen_reg;
    logic oen_next;
    logic wake_reg;
    logic wake_next;
    logic irq_reg;
    logic irq_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic evt_byte;
    logic evt_match;
    logic acc_done;
    logic wr_ctrl;
    logic wr_data;
    logic mapped;

    // Only the second and third stages feed the edge and condition detectors.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_reg <= 2'h3;
            pin_s2_reg <= 2'h3;
            pin_s3_reg <= 2'h3;
        end else if (ce) begin
            pin_s1_reg <= '{scl: scl_in, sda: sda_in};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    assign scl_rise = pin_s2_reg.scl & ~pin_s3_reg.scl;
    assign scl_fall = ~pin_s2_reg.scl & pin_s3_reg.scl;
    assign bus_start = pin_s2_reg.scl & pin_s3_reg.scl & pin_s3_reg.sda & ~pin_s2_reg.sda;
    assign bus_stop = pin_s2_reg.scl & pin_s3_reg.scl & ~pin_s3_reg.sda & pin_s2_reg.sda;

    assign acc_done = psel & penable & pready_reg;
    assign wr_ctrl = acc_done & pwrite & (paddr == `I2CSS_OFF_CTRL);
    assign wr_data = acc_done & pwrite & (paddr == `I2CSS_OFF_DATA);

    // Link state, control flags and the data register. Bus writes are applied first so
    // that a byte arriving in the same cycle overwrites the data register.
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        oen_next = oen_reg;
        ctl_next = ctl_reg;
        dat_next = dat_reg;
        wake_next = 1'b0;
        evt_byte = 1'b0;
        evt_match = 1'b0;
        if (wr_ctrl) begin
            ctl_next.transmit_select = pwdata[`I2CSS_BIT_TX_SEL];
            ctl_next.ack_to_send = pwdata[`I2CSS_BIT_ACK_TO_SEND];
            ctl_next.match_wake_enable = pwdata[`I2CSS_BIT_WAKE_EN];
        end
        if (wr_data) begin
            dat_next = pwdata[7:0]; // [R12] [R13] [R15]
        end
        if (bus_start) begin
            st_next = i2css_pkg::ST_ADDR;
            cnt_next = 4'h0;
            oen_next = 1'b1;
            ctl_next.bus_busy_flag = 1'b1; // [R3]
            ctl_next.addr_match_flag = 1'b0;
            ctl_next.byte_done_flag = 1'b0; // [R17]
        end else if (bus_stop) begin
            st_next = i2css_pkg::ST_IDLE;
            oen_next = 1'b1;
            ctl_next.bus_busy_flag = 1'b0; // [R16]
        end else if (scl_rise) begin
            unique case (st_reg)
                i2css_pkg::ST_ADDR, i2css_pkg::ST_RX, i2css_pkg::ST_TX: begin
                    sh_next = {sh_reg[6:0], pin_s2_reg.sda};
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `I2CSS_LAST_BIT) begin
                        if (st_reg == i2css_pkg::ST_ADDR) begin
                            ctl_next.master_read_request = pin_s2_reg.sda; // [R4]
                        end else begin
                            ctl_next.byte_done_flag = 1'b1; // [R1] [R17]
                            evt_byte = 1'b1; // [R1]
                        end
                        if (st_reg == i2css_pkg::ST_RX) begin
                            dat_next = {sh_reg[6:0], pin_s2_reg.sda}; // [R14]
                        end
                    end
                    if (st_reg == i2css_pkg::ST_TX) begin
                        sh_next = sh_reg;
                    end
                end
                i2css_pkg::ST_TX_ACK: begin
                    ctl_next.ack_received_n = pin_s2_reg.sda; // [R9]
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_reg)
                i2css_pkg::ST_ADDR: begin
                    if (cnt_reg == `I2CSS_BYTE_BITS) begin
                        cnt_next = 4'h0;
                        if (sh_reg[7:1] == own_reg) begin
                            st_next = i2css_pkg::ST_ADDR_ACK;
                            oen_next = 1'b0;
                            ctl_next.addr_match_flag = 1'b1; // [R2]
                            evt_match = 1'b1; // [R2]
                            wake_next = ctl_reg.match_wake_enable; // [R8]
                        end else begin
                            st_next = i2css_pkg::ST_IGNORE;
                        end
                    end
                end
                i2css_pkg::ST_ADDR_ACK: begin
                    ctl_next.byte_done_flag = 1'b0; // [R17]
                    if (ctl_reg.transmit_select) begin
                        st_next = i2css_pkg::ST_TX; // [R5]
                        sh_next = dat_reg;
                        oen_next = dat_reg[7];
                    end else begin
                        st_next = i2css_pkg::ST_RX; // [R5]
                        oen_next = 1'b1;
                    end
                end
                i2css_pkg::ST_RX: begin
                    if (cnt_reg == `I2CSS_BYTE_BITS) begin
                        st_next = i2css_pkg::ST_RX_ACK;
                        cnt_next = 4'h0;
                        oen_next = ctl_reg.ack_to_send; // [R6]
                    end
                end
                i2css_pkg::ST_RX_ACK: begin
                    st_next = i2css_pkg::ST_RX;
                    oen_next = 1'b1;
                    ctl_next.byte_done_flag = 1'b0; // [R17]
                end
                i2css_pkg::ST_TX: begin
                    if (cnt_reg == `I2CSS_BYTE_BITS) begin
                        st_next = i2css_pkg::ST_TX_ACK;
                        cnt_next = 4'h0;
                        oen_next = 1'b1;
                    end else begin
                        sh_next = {sh_reg[6:0], 1'b0};
                        oen_next = sh_reg[6];
                    end
                end
                i2css_pkg::ST_TX_ACK: begin
                    if (!ctl_reg.ack_received_n) begin
                        st_next = i2css_pkg::ST_TX; // [R10]
                        sh_next = dat_reg;
                        oen_next = dat_reg[7];
                        ctl_next.byte_done_flag = 1'b0; // [R17]
                    end else begin
                        st_next = i2css_pkg::ST_IGNORE; // [R10]
                        oen_next = 1'b1; // [R11]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // A start seen after a stretch of noise always resynchronises the link state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= i2css_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            oen_reg <= 1'b1;
            ctl_reg <= `I2CSS_CTRL_RESET;
            wake_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            oen_reg <= oen_next;
            ctl_reg <= ctl_next;
            wake_reg <= wake_next;
        end
    end

    // The data register has no reset value, so software must load it before use.
    always_ff @(posedge clk) begin
        if (ce) begin
            dat_reg <= dat_next; // [R15]
        end
    end

    assign mapped = (paddr == `I2CSS_OFF_CTRL) || (paddr == `I2CSS_OFF_DATA) ||
                    (paddr == `I2CSS_OFF_OWN) || (paddr == `I2CSS_OFF_INT) ||
                    (paddr == `I2CSS_OFF_MASK);

    // APB slave with one wait state. Read data is captured when pready rises, and a
    // status read clears only the bits it returned, so an event in between survives.
    always_comb begin
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        own_next = own_reg;
        mask_next = mask_reg;
        int_next = int_reg;
        if (psel && penable && !pready_reg) begin
            pready_next = 1'b1;
            pslverr_next = ~mapped;
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `I2CSS_OFF_CTRL: prdata_next[7:0] = ctl_reg;
                    `I2CSS_OFF_DATA: prdata_next[7:0] = dat_reg; // [R14]
                    `I2CSS_OFF_OWN: prdata_next[7:0] = {own_reg, 1'b0};
                    `I2CSS_OFF_INT: prdata_next[1:0] = int_reg;
                    `I2CSS_OFF_MASK: prdata_next[1:0] = mask_reg;
                    default: prdata_next = 32'h0000_0000;
                endcase
            end
        end
        if (acc_done && pwrite && (paddr == `I2CSS_OFF_OWN)) begin
            own_next = pwdata[7:1];
        end
        if (acc_done && pwrite && (paddr == `I2CSS_OFF_MASK)) begin
            mask_next = pwdata[1:0];
        end
        if (acc_done && !pwrite && (paddr == `I2CSS_OFF_INT)) begin
            int_next = int_reg & ~prdata_reg[1:0];
        end
        int_next[`I2CSS_INT_BYTE] = int_next[`I2CSS_INT_BYTE] | evt_byte; // [R1]
        int_next[`I2CSS_INT_MATCH] = int_next[`I2CSS_INT_MATCH] | evt_match; // [R2]
        irq_next = |(int_next & mask_next);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            own_reg <= `I2CSS_OWN_RESET;
            mask_reg <= `I2CSS_INT_RESET;
            int_reg <= `I2CSS_INT_RESET;
            irq_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            own_reg <= own_next;
            mask_reg <= mask_next;
            int_reg <= int_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sda_out = 1'b0;
    assign sda_oe_n = oen_reg;
    assign irq = irq_reg;
    assign wake = wake_reg;

endmodule : i2css_top

// ---- rtl/i2css_consts.svh ----
// Register offsets, field positions, reset values and bit counts of the serial slave block.
`ifndef I2CSS_CONSTS_SVH
`define I2CSS_CONSTS_SVH

`define I2CSS_OFF_CTRL 8'h00
`define I2CSS_OFF_DATA 8'h04
`define I2CSS_OFF_OWN 8'h08
`define I2CSS_OFF_INT 8'h0C
`define I2CSS_OFF_MASK 8'h10

`define I2CSS_CTRL_RESET 8'h81
`define I2CSS_OWN_RESET 7'h00
`define I2CSS_INT_RESET 2'h0

`define I2CSS_BIT_TX_SEL 4
`define I2CSS_BIT_ACK_TO_SEND 3
`define I2CSS_BIT_WAKE_EN 1

`define I2CSS_INT_BYTE 0
`define I2CSS_INT_MATCH 1

`define I2CSS_LAST_BIT 4'h7
`define I2CSS_BYTE_BITS 4'h8

`endif

// ---- rtl/i2css_pkg.sv ----
// Types shared by the serial slave block.
package i2css_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } i2css_state_t;

    typedef struct packed {
        logic byte_done_flag;
        logic addr_match_flag;
        logic bus_busy_flag;
        logic transmit_select;
        logic ack_to_send;
        logic master_read_request;
        logic match_wake_enable;
        logic ack_received_n;
    } i2css_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2css_pins_t;

endpackage : i2css_pkg

// ---- dv/i2css_props.sv ----
// Port checker for the serial slave register block.
`timescale 1ns/1ps
module i2css_props #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic irq,
    input wire logic wake
);
    logic wake_en_reg;
    logic rd_int;
    logic msk_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign rd_int = pready && !pwrite && paddr == 8'h0C;
    assign msk_wr = pready && pwrite && paddr == 8'h10;
    // Shadow of the wake enable bit, so a wake pulse can be tied to consent.
    always_ff @(posedge clk)
        if (!rst_n) wake_en_reg <= 1'b0;
        else if (pready && pwrite && paddr == 8'h00) wake_en_reg <= pwdata[1];
    a_ready_one_wait: assert property (penable && !pready |=> pready)
        else $error("ready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held");
    a_unmapped_err: assert property (pready && paddr > 8'h10 |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_wake_one_pulse: assert property (wake |=> !wake)
        else $error("wake held");
    a_wake_needs_enable: assert property (wake |-> wake_en_reg)
        else $error("wake while disabled");
    a_sda_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("sda moved with scl high");
    a_irq_drop_cause: assert property ($fell(irq) |->
        $past(rd_int) || $past(rd_int, 2) || $past(msk_wr) || $past(msk_wr, 2))
        else $error("irq fell without read");
endmodule : i2css_props

bind i2css_top i2css_props #(.ADDR_W(ADDR_W)) i2css_props_inst (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .irq(irq),
    .wake(wake));

// ---- dv/i2css_master.sv ----
// Behavioural bus master driving the serial link of the slave block.
`timescale 1ns/1ps
module i2css_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_bus
);
    // Lines idle released; the clock stands high between frames.
    initial {scl, sda_drv} = 2'b11;
    // Data moves mid-low; the long low phase leaves the slave time to answer.
    task automatic bit_io(input logic b, output logic r);
        #300 sda_drv = b;
        #300 scl = 1'b1;
        #100 r = sda_bus;
        #100 scl = 1'b0;
    endtask : bit_io
    task automatic start;
        #313 scl = 1'b1;
        #300 sda_drv = 1'b0;
        #300 scl = 1'b0;
    endtask : start
    task automatic stop;
        #313 sda_drv = 1'b0;
        #300 scl = 1'b1;
        #300 sda_drv = 1'b1;
        // Bus free time, so the slave has taken the stop before anyone looks at it.
        #400;
    endtask : stop
    task automatic wr_bits(input logic [7:0] d);
        logic r;
        #13;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    endtask : wr_bits
    // The ninth clock alone lets the bench look at the flags before the acknowledge.
    task automatic ack_bit(input logic b, output logic r);
        #13;
        bit_io(b, r);
    endtask : ack_bit
    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        wr_bits(d);
        bit_io(1'b1, ack_n);
    endtask : wr_byte
    // A high ninth bit tells the slave to stop sending.
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        #13;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask : rd_byte
endmodule : i2css_master

// ---- dv/i2css_top_test.sv ----
// Directed bench for the serial slave block, its registers and its bus link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module i2css_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, scl, m_sda, sda_out, sda_oe_n, irq, wake, err, ack_n;
    logic wake_seen = 1'b0;
    logic [7:0] rd, rx;
    int error_cnt = 0;
    int compares = 0;
    // Open-drain data line with pull-up: low while either side pulls it.
    wire sda_bus = m_sda & (sda_oe_n | sda_out);
    always #50 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wake_seen <= 1'b1;
    i2css_top i2css_top_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq), .wake(wake));
    i2css_master i2css_master_inst (.scl(scl), .sda_drv(m_sda), .sda_bus(sda_bus));
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
        input string nm);
        apb(a, 1'b0, 8'h00);
        `CHK(nm, e, rd & m)
    endtask : rdc
    task automatic print_verdict;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h00, 8'hFF, 8'h81, "ctrl reset");
        apb(8'h14, 1'b0, 8'h00);
        `CHK("unmapped", 9'h100, {err, rd})
        apb(8'h04, 1'b1, 8'hA5);
        rdc(8'h04, 8'hFF, 8'hA5, "data rw");
        apb(8'h00, 1'b1, 8'hFF);
        rdc(8'h00, 8'hFF, 8'h9B, "ctrl rw");
        $display("test registers done");
        apb(8'h08, 1'b1, 8'h54);
        apb(8'h10, 1'b1, 8'h03);
        rdc(8'h08, 8'hFF, 8'h54, "own addr");
        rdc(8'h10, 8'hFF, 8'h03, "mask");
        apb(8'h00, 1'b1, 8'h02);
        i2css_master_inst.start();
        i2css_master_inst.wr_byte(8'h54, ack_n);
        `CHK("addr ack", 2'b01, {ack_n, irq})
        `CHK("wake", 1'b1, wake_seen)
        rdc(8'h00, 8'h7E, 8'h62, "ctrl match");
        rdc(8'h0C, 8'hFF, 8'h02, "int match");
        #250;
        `CHK("irq clear", 1'b0, irq)
        i2css_master_inst.wr_bits(8'hC3);
        rdc(8'h00, 8'h80, 8'h80, "byte done");
        i2css_master_inst.ack_bit(1'b1, ack_n);
        `CHK("data ack", 1'b0, ack_n)
        rdc(8'h04, 8'hFF, 8'hC3, "rx data");
        rdc(8'h00, 8'h80, 8'h00, "byte shifting");
        rdc(8'h0C, 8'hFF, 8'h01, "int byte");
        apb(8'h00, 1'b1, 8'h0A);
        i2css_master_inst.wr_byte(8'h3C, ack_n);
        `CHK("data nack", 1'b1, ack_n)
        i2css_master_inst.stop();
        rdc(8'h00, 8'h20, 8'h00, "bus free");
        rdc(8'h04, 8'hFF, 8'h3C, "rx data 2");
        rdc(8'h0C, 8'hFF, 8'h01, "int byte 2");
        $display("test receive done");
        i2css_master_inst.start();
        i2css_master_inst.wr_byte(8'h56, ack_n);
        `CHK("no match ack", 1'b1, ack_n)
        i2css_master_inst.stop();
        rdc(8'h0C, 8'hFF, 8'h00, "int none");
        $display("test mismatch done");
        apb(8'h10, 1'b1, 8'h01);
        // A leading zero makes a wrongly resumed transmit pull the line after a nack.
        apb(8'h04, 1'b1, 8'h69);
        apb(8'h00, 1'b1, 8'h10);
        wake_seen <= 1'b0;
        i2css_master_inst.start();
        i2css_master_inst.wr_byte(8'h55, ack_n);
        `CHK("read addr ack", 2'b00, {ack_n, irq})
        rdc(8'h00, 8'h04, 8'h04, "read req");
        i2css_master_inst.rd_byte(1'b0, rx);
        `CHK("tx byte", 9'h169, {irq, rx})
        rdc(8'h00, 8'h01, 8'h00, "ack got");
        i2css_master_inst.rd_byte(1'b1, rx);
        `CHK("tx byte 2", 8'h69, rx)
        rdc(8'h00, 8'h01, 8'h01, "nack got");
        #450;
        `CHK("sda released", 1'b1, sda_oe_n)
        i2css_master_inst.stop();
        `CHK("no wake", 1'b0, wake_seen)
        $display("test transmit done");
        print_verdict();
    end
endmodule : i2css_top_test
